// [rtl/tfs_status_flags.sv]
// status flag register with limit comparison, alert outputs and AXI4-Lite slave
`timescale 1ns/1ns

module tfs_status_flags
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input tfs_pkg::tfs_meas_t meas, // measurement results
  input wire logic monitor_tick, // one pulse per monitoring cycle
  input wire logic spin_up, // fan spin-up in progress
  input wire logic remote_fault_pin, // remote sensor short or open
  output logic [7:0] remote_temp_result, // remote result, forced on fault
  output logic alert_n, // bus alert, low
  output logic overtemp_out_n, // sensor fault, low
  output logic heat_limit_pin_n, // heat limit, low
  output logic fan_fail_n // fan failure, low
);
  import tfs_pkg::*;

  logic [7:0] status;
  logic [2:0] ctrl;
  tfs_tlim_t tlim;
  logic [7:0] crit_limit;
  tfs_flim_t flim;
  logic soft_reset;
  logic fault_meta;
  logic fault_sync;
  logic crit_armed;
  logic overspeed_armed;
  logic [2:0] slow_run;
  logic fan_fail;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic do_read;
  logic status_read;
  logic [7:0] next_status;
  logic [7:0] set_mask;
  logic [7:0] clear_mask;
  logic local_low_hit;
  logic local_high_hit;
  logic remote_low_hit;
  logic remote_high_hit;
  logic remote_crit_hit;
  logic remote_cooled;
  logic slow_hit;
  logic overspeed_hit;
  logic [31:0] read_word;
  logic read_hit;
  logic flag_reset;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return result;
  endfunction

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arready && s_axi_arvalid;
  assign status_read = do_read && (s_axi_araddr == STATUS_ADDR);
  assign flag_reset = !aresetn || soft_reset;

  // limit comparisons; temperatures are two's complement
  assign local_low_hit = $signed(meas.local_temp) <= $signed(tlim.local_low);
  assign local_high_hit = $signed(meas.local_temp) >= $signed(tlim.local_high);
  assign remote_low_hit = $signed(remote_temp_result) <= $signed(tlim.remote_low);
  assign remote_high_hit = $signed(remote_temp_result) >= $signed(tlim.remote_high);
  assign remote_crit_hit = $signed(remote_temp_result) > $signed(crit_limit);
  // nine bits so a limit near minus 128 does not wrap
  assign remote_cooled = $signed({remote_temp_result[7], remote_temp_result})
    <= ($signed({crit_limit[7], crit_limit}) - CRIT_HYST);
  assign slow_hit = !spin_up && (meas.rotation_period_count >= flim.slow_limit);
  assign overspeed_hit = meas.rotation_period_count <= flim.overspeed_limit;

  // fault pin crosses in from outside the clock domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end
    else
    begin
      fault_meta <= remote_fault_pin;
      fault_sync <= fault_meta;
    end
  end

  always_comb
  begin
    set_mask = 8'h00;
    if (monitor_tick)
    begin
      set_mask[LOCAL_LOW_BIT] = local_low_hit;
      set_mask[LOCAL_HIGH_BIT] = local_high_hit;
      set_mask[REMOTE_CRIT_BIT] = remote_crit_hit && crit_armed;
      set_mask[REMOTE_LOW_BIT] = remote_low_hit;
      set_mask[REMOTE_HIGH_BIT] = remote_high_hit;
      set_mask[FAN_SLOW_BIT] = slow_hit;
      set_mask[OVERSPEED_BIT] = overspeed_hit && overspeed_armed;
    end
    // fault is caught at once, not only at the monitoring cycle
    set_mask[SENSOR_FAULT_BIT] = fault_sync;
  end

  always_comb
  begin
    clear_mask = 8'h00;
    if (status_read)
    begin
      clear_mask = 8'hff;
      clear_mask[SENSOR_FAULT_BIT] = 1'b0;
    end
    next_status = (status & ~clear_mask) | set_mask;
  end

  always_ff @(posedge aclk)
  begin
    if (flag_reset)
    begin
      status <= STATUS_RESET;
    end
    else
    begin
      status <= next_status;
    end
  end

  // re-arm tracking for the two flags that do not re-set on a persisting cause
  always_ff @(posedge aclk)
  begin
    if (flag_reset)
    begin
      crit_armed <= 1'b1;
      overspeed_armed <= 1'b1;
    end
    else
    begin
      if (status_read && status[REMOTE_CRIT_BIT] && !set_mask[REMOTE_CRIT_BIT])
      begin
        crit_armed <= 1'b0;
      end
      else if (monitor_tick && remote_cooled)
      begin
        crit_armed <= 1'b1;
      end
      if (status_read && status[OVERSPEED_BIT] && !set_mask[OVERSPEED_BIT])
      begin
        overspeed_armed <= 1'b0;
      end
      else if (monitor_tick && !overspeed_hit)
      begin
        overspeed_armed <= 1'b1;
      end
    end
  end

  // consecutive slow detections; a good cycle ends the run
  always_ff @(posedge aclk)
  begin
    if (flag_reset)
    begin
      slow_run <= 3'd0;
      fan_fail <= 1'b0;
    end
    else if (monitor_tick && !spin_up)
    begin
      if (slow_hit)
      begin
        if (slow_run != FAIL_COUNT)
        begin
          slow_run <= slow_run + 3'd1;
        end
        fan_fail <= (slow_run >= FAIL_COUNT - 3'd1);
      end
      else
      begin
        slow_run <= 3'd0;
        fan_fail <= 1'b0;
      end
    end
  end

  // pin outputs, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remote_temp_result <= 8'h00;
      alert_n <= 1'b1;
      overtemp_out_n <= 1'b1;
      heat_limit_pin_n <= 1'b1;
      fan_fail_n <= 1'b1;
    end
    else
    begin
      remote_temp_result <= fault_sync ? FAULT_TEMP : meas.remote_temp;
      overtemp_out_n <= !status[SENSOR_FAULT_BIT];
      heat_limit_pin_n <= !status[REMOTE_CRIT_BIT];
      // overspeed stays off this output by design
      fan_fail_n <= !fan_fail;
      alert_n <= !((status[SENSOR_FAULT_BIT] && ctrl[SENSOR_FAULT_IE_BIT])
        || (status[REMOTE_CRIT_BIT] && ctrl[OVERTEMP_IE_BIT])
        || (status[FAN_SLOW_BIT] && ctrl[FAN_RANGE_IE_BIT])
        || (status[OVERSPEED_BIT] && ctrl[FAN_RANGE_IE_BIT]));
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (!aw_held && !s_axi_bvalid)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (!w_held && !s_axi_bvalid)
      begin
        s_axi_wready <= 1'b1;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr)
          STATUS_ADDR, CTRL_ADDR, TLIM_ADDR, CRIT_ADDR, FLIM_ADDR, STATE_ADDR: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_DECERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers; status and state words ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RESET;
      tlim <= TLIM_RESET;
      crit_limit <= CRIT_RESET;
      flim <= FLIM_RESET;
      soft_reset <= 1'b0;
    end
    else
    begin
      soft_reset <= 1'b0;
      if (do_write)
      begin
        if (aw_addr == CTRL_ADDR && w_strb[0])
        begin
          ctrl <= w_data[2:0];
          soft_reset <= w_data[SOFT_RESET_BIT];
        end
        if (aw_addr == TLIM_ADDR)
        begin
          tlim <= merge(tlim, w_data, w_strb);
        end
        if (aw_addr == CRIT_ADDR && w_strb[0])
        begin
          crit_limit <= w_data[7:0];
        end
        if (aw_addr == FLIM_ADDR)
        begin
          flim <= merge(flim, w_data, w_strb);
        end
      end
    end
  end

  always_comb
  begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    unique case (s_axi_araddr)
      STATUS_ADDR: read_word = {24'h0, status};
      CTRL_ADDR: read_word = {29'h0, ctrl};
      TLIM_ADDR: read_word = tlim;
      CRIT_ADDR: read_word = {24'h0, crit_limit};
      FLIM_ADDR: read_word = flim;
      STATE_ADDR: read_word = {23'h0, fan_fail, remote_temp_result};
      default: read_hit = 1'b0;
    endcase
  end

  // read channel: data is the value before this read's clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      if (do_read)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      else if (!s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // tfs_status_flags

// [rtl/tfs_pkg.sv]
// package of constants and carrier types for the temperature and fan status flag block
package tfs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] STATUS_IDX = 8'h02;
  localparam logic [7:0] CTRL_IDX = 8'h10;
  localparam logic [7:0] TLIM_IDX = 8'h11;
  localparam logic [7:0] CRIT_IDX = 8'h12;
  localparam logic [7:0] FLIM_IDX = 8'h13;
  localparam logic [7:0] STATE_IDX = 8'h14;
  localparam logic [31:0] STATUS_ADDR = {22'h0, STATUS_IDX, 2'b00};
  localparam logic [31:0] CTRL_ADDR = {22'h0, CTRL_IDX, 2'b00};
  localparam logic [31:0] TLIM_ADDR = {22'h0, TLIM_IDX, 2'b00};
  localparam logic [31:0] CRIT_ADDR = {22'h0, CRIT_IDX, 2'b00};
  localparam logic [31:0] FLIM_ADDR = {22'h0, FLIM_IDX, 2'b00};
  localparam logic [31:0] STATE_ADDR = {22'h0, STATE_IDX, 2'b00};
  // status bit positions
  localparam int LOCAL_LOW_BIT = 7;
  localparam int LOCAL_HIGH_BIT = 6;
  localparam int SENSOR_FAULT_BIT = 5;
  localparam int REMOTE_CRIT_BIT = 4;
  localparam int REMOTE_LOW_BIT = 3;
  localparam int REMOTE_HIGH_BIT = 2;
  localparam int FAN_SLOW_BIT = 1;
  localparam int OVERSPEED_BIT = 0;
  // control bit positions, and the fan failure bit of the state word
  localparam int SENSOR_FAULT_IE_BIT = 0;
  localparam int OVERTEMP_IE_BIT = 1;
  localparam int FAN_RANGE_IE_BIT = 2;
  localparam int SOFT_RESET_BIT = 3;
  localparam int FAN_FAIL_STATE_BIT = 8;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] TLIM_RESET = 32'h7f7f_8080;
  localparam logic [7:0] CRIT_RESET = 8'h7f;
  localparam logic [31:0] FLIM_RESET = 32'h0000_ffff;
  // behaviour constants
  localparam logic [7:0] FAULT_TEMP = 8'h80;
  localparam logic signed [8:0] CRIT_HYST = 9'sd5;
  localparam logic [2:0] FAIL_COUNT = 3'd5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] remote_temp;
    logic [15:0] rotation_period_count;
  } tfs_meas_t;

  typedef struct packed {
    logic [7:0] local_low;
    logic [7:0] local_high;
    logic [7:0] remote_low;
    logic [7:0] remote_high;
  } tfs_tlim_t;

  typedef struct packed {
    logic [15:0] overspeed_limit;
    logic [15:0] slow_limit;
  } tfs_flim_t;
endpackage

// [dv/tfs_status_flags_assertions.sv]
// checker for the status flag block, bound to its top module
`timescale 1ns/1ns
module tfs_status_flags_checker
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic monitor_tick, // cycle pulse
  input wire logic spin_up, // spin-up
  input wire logic remote_fault_pin, // sensor fault
  input wire logic [7:0] remote_temp_result, // remote result
  input wire logic overtemp_out_n, // overtemp pin
  input wire logic heat_limit_pin_n, // heat pin
  input wire logic fan_fail_n // fan failure pin
);
  import tfs_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_stat;
  logic rd_flt;
  // pin low on two edges rules out a soft reset landing between them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_stat <= 1'b0;
      rd_flt <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rd_stat <= s_axi_araddr == STATUS_ADDR;
      rd_flt <= !overtemp_out_n;
    end
  end
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_status_upper: assert property (s_axi_rvalid && rd_stat |-> s_axi_rdata[31:8] == 24'h0)
    else $error("status upper bits set");
  chk_fault_read: assert property (s_axi_rvalid && rd_stat && rd_flt && !overtemp_out_n |-> s_axi_rdata[5])
    else $error("sensor fault flag lost");
  chk_fault_result: assert property (remote_fault_pin [*3] |=> remote_temp_result == FAULT_TEMP)
    else $error("remote result not forced");
  chk_fault_pin: assert property (remote_fault_pin [*5] |=> !overtemp_out_n)
    else $error("overtemp pin not asserted");
  chk_heat_timing: assert property ($fell(heat_limit_pin_n) |-> $past(monitor_tick, 2))
    else $error("heat pin fell without tick");
  chk_fail_tick: assert property ($fell(fan_fail_n) |-> $past(monitor_tick, 2) && !$past(spin_up, 2))
    else $error("fan failure without counted tick");
  cover property ($fell(heat_limit_pin_n));
  cover property ($fell(fan_fail_n));
  cover property (s_axi_rvalid && rd_stat && rd_flt);
endmodule // tfs_status_flags_checker

bind tfs_status_flags tfs_status_flags_checker chk_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .monitor_tick, .spin_up, .remote_fault_pin,
  .remote_temp_result, .overtemp_out_n, .heat_limit_pin_n, .fan_fail_n);

// [dv/tfs_host_model.sv]
// register bus host model issuing single reads and writes
`timescale 1ns/1ns
module tfs_host_model
(
  input wire logic aclk, // clock
  output logic [31:0] s_axi_awaddr, // write address
  output logic [2:0] s_axi_awprot, // prot
  output logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // strobes
  output logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // b valid
  output logic s_axi_bready, // b ready
  output logic [31:0] s_axi_araddr, // read address
  output logic [2:0] s_axi_arprot, // prot
  output logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  output logic s_axi_rready // r ready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // each task opens with an edge so strobes never toggle twice in one step
  task automatic write_reg(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (s_axi_awready && !aw_done)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_done)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic read_reg(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready)
      @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_axi_rvalid)
      @(posedge aclk);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // tfs_host_model

// [dv/tfs_status_flags_tb_top.sv]
// self-checking testbench for the status flag block
`timescale 1ns/1ns
module tfs_status_flags_tb_top;
  import tfs_pkg::*;
  localparam logic [7:0] L_LO = 8'hf6;
  localparam logic [7:0] L_HI = 8'h28;
  localparam logic [7:0] R_LO = 8'h00;
  localparam logic [7:0] R_HI = 8'h32;
  localparam logic [7:0] N = 8'h14;
  localparam logic [15:0] MID = 16'h0800;
  logic aclk, aresetn, monitor_tick, spin_up, remote_fault_pin;
  tfs_meas_t meas;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] remote_temp_result, lt, rt;
  logic alert_n, overtemp_out_n, heat_limit_pin_n, fan_fail_n;
  int num_errors = 0;
  int check_count = 0;
  int seed = 26;

  tfs_status_flags DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .meas, .monitor_tick, .spin_up, .remote_fault_pin, .remote_temp_result, .alert_n,
    .overtemp_out_n, .heat_limit_pin_n, .fan_fail_n);
  tfs_host_model host (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // remote value takes one cycle to reach the compare, so tick one edge late
  task automatic tick(input logic [7:0] l, input logic [7:0] r, input logic [15:0] c);
    meas <= {l, r, c};
    @(posedge aclk);
    monitor_tick <= 1'b1;
    @(posedge aclk);
    monitor_tick <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic sts(input string what, input logic [7:0] mask, input logic [7:0] exp);
    host.read_reg(STATUS_ADDR, rd, rsp);
    check(what, {24'h0, rd[7:0] & mask}, {24'h0, exp & mask});
  endtask

  function automatic logic [7:0] exp_temp(input logic [7:0] l, input logic [7:0] r);
    exp_temp = 8'h00;
    exp_temp[LOCAL_LOW_BIT] = $signed(l) <= $signed(L_LO);
    exp_temp[LOCAL_HIGH_BIT] = $signed(l) >= $signed(L_HI);
    exp_temp[REMOTE_LOW_BIT] = $signed(r) <= $signed(R_LO);
    exp_temp[REMOTE_HIGH_BIT] = $signed(r) >= $signed(R_HI);
  endfunction

  initial
  begin
    #200_000;
    num_errors++;
    summarize();
  end

  initial
  begin
    aresetn = 1'b0;
    monitor_tick = 1'b0;
    spin_up = 1'b0;
    remote_fault_pin = 1'b0;
    meas = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sts("status reset", 8'hff, STATUS_RESET);
    host.read_reg(TLIM_ADDR, rd, rsp);
    check("tlim reset", rd, TLIM_RESET);
    host.read_reg(32'h0000_03fc, rd, rsp);
    check("unmapped resp", {30'h0, rsp}, {30'h0, RESP_DECERR});
    host.write_reg(TLIM_ADDR, {L_LO, L_HI, R_LO, R_HI}, rsp);
    check("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    host.write_reg(32'h0000_03fc, 32'h0000_0000, rsp);
    check("unmapped write", {30'h0, rsp}, {30'h0, RESP_DECERR});
    host.write_reg(CRIT_ADDR, 32'h0000_003c, rsp);
    host.write_reg(FLIM_ADDR, 32'h0100_1000, rsp);
    host.read_reg(CRIT_ADDR, rd, rsp);
    check("crit readback", rd, 32'h0000_003c);
    for (int i = 0; i < 24; i++)
    begin
      lt = 8'($random(seed));
      rt = 8'($random(seed));
      if (i == 0) {lt, rt} = {L_LO, R_LO};
      if (i == 1) {lt, rt} = {L_HI, R_HI};
      if (i == 2) {lt, rt} = {L_LO + 8'h01, R_LO + 8'h01};
      if (i == 3) {lt, rt} = {L_HI - 8'h01, R_HI - 8'h01};
      tick(lt, rt, MID);
      sts("temp flags", 8'hcc, exp_temp(lt, rt));
    end
    tick(L_LO, N, MID);
    tick(N, N, MID);
    sts("sticky low", 8'hcc, 8'h80);
    sts("cleared low", 8'hcc, 8'h00);
    // tick lands on the very edge that takes the clearing read
    meas <= {L_LO, N, MID};
    fork
      host.read_reg(STATUS_ADDR, rd, rsp);
      begin
        @(posedge aclk);
        monitor_tick <= 1'b1;
        @(posedge aclk);
        monitor_tick <= 1'b0;
      end
    join
    sts("set beats clear", 8'h80, 8'h80);
    for (int en = 0; en < 2; en++)
    begin
      host.write_reg(CTRL_ADDR, en ? 32'h0000_0002 : 32'h0000_0000, rsp);
      tick(N, 8'h37, MID);
      tick(N, 8'h3c, MID);
      sts("crit equal", 8'h10, 8'h00);
      tick(N, 8'h3d, MID);
      check("heat pin", {31'h0, heat_limit_pin_n}, 32'h0000_0000);
      check("crit alert", {31'h0, alert_n}, en ? 32'h0000_0000 : 32'h0000_0001);
      sts("crit set", 8'h10, 8'h10);
      tick(N, 8'h3d, MID);
      tick(N, 8'h38, MID);
      tick(N, 8'h3d, MID);
      sts("crit held off", 8'h10, 8'h00);
    end
    host.write_reg(CTRL_ADDR, 32'h0000_0004, rsp);
    tick(N, N, 16'h0101);
    tick(N, N, 16'h0100);
    check("overspeed alert", {31'h0, alert_n}, 32'h0000_0000);
    sts("overspeed set", 8'h01, 8'h01);
    tick(N, N, 16'h0100);
    sts("overspeed held off", 8'h01, 8'h00);
    check("overspeed no fail", {31'h0, fan_fail_n}, 32'h0000_0001);
    spin_up <= 1'b1;
    repeat (5) tick(N, N, 16'h1000);
    sts("spin-up slow", 8'h02, 8'h00);
    spin_up <= 1'b0;
    repeat (4) tick(N, N, 16'h1000);
    check("fail early", {31'h0, fan_fail_n}, 32'h0000_0001);
    tick(N, N, 16'h1000);
    check("fail fifth", {31'h0, fan_fail_n}, 32'h0000_0000);
    check("slow alert", {31'h0, alert_n}, 32'h0000_0000);
    sts("slow set", 8'h02, 8'h02);
    host.write_reg(CTRL_ADDR, 32'h0000_0001, rsp);
    remote_fault_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    check("fault result", {24'h0, remote_temp_result}, {24'h0, FAULT_TEMP});
    check("fault pin", {31'h0, overtemp_out_n}, 32'h0000_0000);
    check("fault alert", {31'h0, alert_n}, 32'h0000_0000);
    host.read_reg(STATE_ADDR, rd, rsp);
    check("state word", rd, {23'h0, 1'b1, FAULT_TEMP});
    remote_fault_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    sts("fault read", 8'h20, 8'h20);
    sts("fault reread", 8'h20, 8'h20);
    host.write_reg(CTRL_ADDR, 32'h0000_0000, rsp);
    repeat (3) @(posedge aclk);
    check("fault masked", {31'h0, alert_n}, 32'h0000_0001);
    host.write_reg(CTRL_ADDR, 32'h0000_0008, rsp);
    sts("soft reset", 8'hff, 8'h00);
    summarize();
  end
endmodule // tfs_status_flags_tb_top
